//--- rtl/pse_pkg.sv
// Constants, types and decoders for the PoE port sequencer
package pse_pkg;

  // ----------------------------------------------------------------
  // Clock and time base
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES_DEF = MS_NS / CLK_PERIOD_NS;
  localparam int CONV_FREQ_KHZ = 250;
  localparam int CONV_HALF_CYC = 1000000 / CONV_FREQ_KHZ / 2 / CLK_PERIOD_NS;
  localparam logic [7:0] CONV_HALF_M1 = 8'(CONV_HALF_CYC - 1);

  // ----------------------------------------------------------------
  // Timer lengths in milliseconds (one tick per ms); OC_UP_STEP and OC_LIMIT are overcurrent counts (16 per ms); CFG_SETTLE is in clock cycles
  // ----------------------------------------------------------------
  localparam logic [11:0] DET_ZERO_MS = 12'd250;
  localparam logic [11:0] DET_STEP_MS = 12'd20;
  localparam logic [11:0] DET_CYCLE_MS = 12'd320;
  localparam logic [11:0] DET_EVAL_MS = DET_CYCLE_MS - DET_ZERO_MS
                                      - 12'd3 * DET_STEP_MS;
  localparam logic [11:0] CLASS_MS = 12'd20;
  localparam logic [11:0] DENY_MS = 12'd2000;
  localparam logic [11:0] ERR_AUTO_MS = 12'd2000;
  localparam logic [11:0] ERR_RST_MS = 12'd2200;
  localparam logic [11:0] BACKOFF_END_MS = 12'd250;
  localparam logic [11:0] BACKOFF_MID_MS = 12'd2000;
  localparam logic [11:0] BLINK_FAST_MS = 12'd100;
  localparam logic [9:0] DISC_MS = 10'd350;
  localparam logic [10:0] OC_UP_STEP = 11'd16;
  localparam logic [10:0] OC_LIMIT = 11'd960;
  localparam logic [2:0] CFG_SETTLE = 3'd4;

  // ----------------------------------------------------------------
  // Duty codes for the averaged control outputs
  // ----------------------------------------------------------------
  localparam logic [7:0] DUTY_ZERO = 8'h00;
  localparam logic [7:0] DUTY_PROBE_LO = 8'h3c;
  localparam logic [7:0] DUTY_PROBE_HI = 8'h64;
  localparam logic [7:0] DUTY_CLASS = 8'h60;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_RESET = 4'h0, ST_WAIT_UV = 4'h1, ST_DET_ZERO = 4'h2,
    ST_DET_P1 = 4'h3, ST_DET_P2 = 4'h4, ST_DET_P3 = 4'h5,
    ST_DET_EVAL = 4'h6, ST_CLASS = 4'h7, ST_DENY = 4'h8,
    ST_RAMP = 4'h9, ST_POWER = 4'ha, ST_SHUT = 4'hb,
    ST_FAULT = 4'hc, ST_BACKOFF = 4'hd
  } pse_state_e;

  // Power level code: 0 = 4.0 W, 1 = 7.0 W, 2 = 15.4 W
  typedef struct packed {
    logic [1:0] pwr;
    logic midspan;
    logic auto_rst;
  } pse_cfg_s;

  // Digitised analog sense results
  typedef struct packed {
    logic [3:0] cfg_level;
    logic in_uv;
    logic out_uv;
    logic signature_good;
    logic cls_6p5;
    logic cls_14p5;
    logic cls_23;
    logic over_cut;
    logic below_min;
    logic at_setpoint;
    logic over_power;
    logic open_circuit;
  } pse_sense_s;

  localparam logic [1:0] THR_400 = 2'd0;
  localparam logic [1:0] THR_98 = 2'd1;
  localparam logic [1:0] THR_180 = 2'd2;

  // Level index 0 is supply, 11 is below 0.25 V
  function automatic pse_cfg_s pse_decode_cfg(input logic [3:0] lvl);
    pse_cfg_s c;
    c = '{pwr: 2'd2, midspan: 1'b0, auto_rst: 1'b1};
    if (lvl <= 4'd2) begin
      c = '{pwr: 2'(4'd2 - lvl), midspan: 1'b0, auto_rst: 1'b1};
    end else if (lvl <= 4'd5) begin
      c = '{pwr: 2'(4'd5 - lvl), midspan: 1'b0, auto_rst: 1'b0};
    end else if (lvl <= 4'd8) begin
      c = '{pwr: 2'(lvl - 4'd6), midspan: 1'b1, auto_rst: 1'b0};
    end else if (lvl <= 4'd11) begin
      c = '{pwr: 2'(lvl - 4'd9), midspan: 1'b1, auto_rst: 1'b1};
    end
    return c;
  endfunction

  // Power level code a class needs
  function automatic logic [1:0] pse_class_need(input logic [2:0] cls);
    return (cls == 3'd1) ? 2'd0 : (cls == 3'd2) ? 2'd1 : 2'd2;
  endfunction

endpackage

//--- rtl/pse_port_sequencer.sv
// Single-port PSE sequencer: detect, classify, soft start, supervise
// Function
// - In reset and at power-up stay inactive, switcher and pass switch off.
// - Sample the configuration level once at power-up and latch the modes.
// - Twelve levels decode to power level, endpoint/midspan, restart policy.
// - After sampling, the configuration pin becomes the LED drive output.
// - Past input undervoltage, detect with output off; no power before detect.
// - Detection holds zero 250 ms, then probes 4.5, 7.5, 4.5 V 20 ms each.
// - Good signature proceeds to classification, else detection repeats.
// - Detection recurs every 320 ms; LED flashes in step with it.
// - After detection, pass switch and converter on at 18 V, 75 mA.
// - Class from sense current thresholds 6.5, 14.5 and 23 mA.
// - Overload threshold 400, 98 or 180 mA by class; hard limit 450 mA.
// - Class above configured power: deny, 10 Hz LED two seconds, redetect.
// - Ramp to -50 V, keep power until fault, LED steady on.
// - Over-power is an error: shut down, fast LED, two seconds or reset.
// - Duty starts at zero, rises slowly; feedback enabled at set point.
// - Current below 7.5 mA beyond 350 ms is a disconnect; stop converter.
// - After disconnect restart after 250 ms endpoint or 2 s midspan.
// - Overcurrent timer up above threshold, down at 1/16; fault at 60 ms.
// - Overcurrent shutdown stops converter clock first, then the switcher.
// - Reset-restart: fast LED, redetect after 2.2 s, power only after open.
// - Undervoltage monitored in detection, classification, ramp and power; reported as fast-flash error.
// - LED: slow flash searching, steady when powered, 10/s on errors.
// - Converter clock is 250 kHz, 50% duty, gated off no later than the switcher.
// - Pass switch output is active low.
// - Two duty outputs set converter duty and detection probe levels.
// - LED on is logic low; reset release starts detection.
`timescale 1ns/1ps
`default_nettype none

module pse_port_sequencer
  import pse_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYCLES_DEF
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire pse_sense_s sense_i,
  output logic led_o,
  output logic led_oe_n_o,
  output logic pass_transistor_n_o,
  output logic switcher_transistor_o,
  output logic converter_clock_out_o,
  output logic duty_out_a_o,
  output logic duty_out_b_o,
  output logic [1:0] overload_threshold_o,
  output logic classify_mode_o,
  output logic feedback_en_o,
  output logic [2:0] class_o
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  pse_sense_s s1_q, s2_q, s3_q, sen_q;

  // Only an agreeing pair of stages updates the used copy
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      sen_q <= '0;
    end else begin
      s1_q <= sense_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        sen_q <= s3_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // Configuration capture and time base
  // ----------------------------------------------------------------
  logic [2:0] settle_q;
  logic cfg_taken_q;
  pse_cfg_s cfg_q;
  logic [16:0] ms_cnt_q;
  wire ms_tick = (ms_cnt_q == 17'(MS_CYCLES - 1));
  wire settle_done = (settle_q == CFG_SETTLE);

  // Wait for the sync chain to fill before trusting the level
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      settle_q <= 3'h0;
      cfg_taken_q <= 1'b0;
      cfg_q <= '0;
      ms_cnt_q <= 17'h0;
    end else begin
      if (!settle_done) begin
        settle_q <= settle_q + 3'h1;
      end
      if (settle_done && !cfg_taken_q) begin
        cfg_taken_q <= 1'b1;
        cfg_q <= pse_decode_cfg(sen_q.cfg_level);
      end
      ms_cnt_q <= ms_tick ? 17'h0 : ms_cnt_q + 17'h1;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  pse_state_e state_q, state_d;
  logic [11:0] tmr_q;
  logic [10:0] oc_q;
  logic [9:0] dis_q;
  logic [2:0] class_q;
  logic fault_q, lock_q;
  logic [7:0] ramp_q;

  wire in_det = (state_q >= ST_DET_ZERO) && (state_q <= ST_DET_EVAL);
  wire supervised = (state_q == ST_RAMP) || (state_q == ST_POWER);
  wire out_live = supervised || (state_q == ST_CLASS);
  wire oc_trip = supervised && (oc_q >= OC_LIMIT);
  wire disc_trip = (state_q == ST_POWER) && (dis_q > DISC_MS);
  wire out_uv_trip = out_live && sen_q.out_uv;
  wire pwr_trip = supervised && sen_q.over_power;
  wire [2:0] class_meas = !sen_q.cls_6p5 ? 3'd0 :
                          !sen_q.cls_14p5 ? 3'd1 :
                          !sen_q.cls_23 ? 3'd2 : 3'd3;
  wire deny = pse_class_need(class_meas) > cfg_q.pwr;
  wire [11:0] err_ms = cfg_q.auto_rst ? ERR_AUTO_MS : ERR_RST_MS;
  wire [11:0] back_ms = cfg_q.midspan ? BACKOFF_MID_MS : BACKOFF_END_MS;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_RESET: if (cfg_taken_q) state_d = ST_WAIT_UV;
      ST_WAIT_UV: if (!sen_q.in_uv) state_d = ST_DET_ZERO;
      ST_DET_ZERO: if (tmr_q >= DET_ZERO_MS) state_d = ST_DET_P1;
      ST_DET_P1: if (tmr_q >= DET_STEP_MS) state_d = ST_DET_P2;
      ST_DET_P2: if (tmr_q >= DET_STEP_MS) state_d = ST_DET_P3;
      ST_DET_P3: if (tmr_q >= DET_STEP_MS) state_d = ST_DET_EVAL;
      ST_DET_EVAL: begin
        if (tmr_q >= DET_EVAL_MS) begin
          state_d = (sen_q.signature_good && !lock_q) ? ST_CLASS
                                                      : ST_DET_ZERO;
        end
      end
      ST_CLASS: begin
        if (tmr_q >= CLASS_MS) state_d = deny ? ST_DENY : ST_RAMP;
      end
      ST_DENY: if (tmr_q >= DENY_MS) state_d = ST_WAIT_UV;
      ST_RAMP: if (sen_q.at_setpoint) state_d = ST_POWER;
      ST_POWER: state_d = ST_POWER;
      ST_SHUT: state_d = fault_q ? ST_FAULT : ST_BACKOFF;
      ST_FAULT: if (tmr_q >= err_ms) state_d = ST_WAIT_UV;
      ST_BACKOFF: if (tmr_q >= back_ms) state_d = ST_WAIT_UV;
      default: state_d = ST_RESET;
    endcase
    if (in_det && sen_q.in_uv) begin
      state_d = ST_FAULT;
    end
    if (oc_trip || disc_trip || out_uv_trip || pwr_trip) begin
      state_d = ST_SHUT;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= ST_RESET;
      tmr_q <= 12'h0;
    end else begin
      state_q <= state_d;
      tmr_q <= (state_d != state_q) ? 12'h0 : tmr_q + {11'h0, ms_tick};
    end
  end

  // Supervision counters, class and restart lock
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      oc_q <= 11'h0;
      dis_q <= 10'h0;
      class_q <= 3'h0;
      fault_q <= 1'b0;
      lock_q <= 1'b0;
      ramp_q <= DUTY_ZERO;
    end else begin
      if (!supervised) begin
        oc_q <= 11'h0;
      end else if (ms_tick && sen_q.over_cut) begin
        oc_q <= oc_q + OC_UP_STEP;
      end else if (ms_tick && oc_q != 11'h0) begin
        oc_q <= oc_q - 11'h1;
      end
      if (state_q != ST_POWER || !sen_q.below_min) begin
        dis_q <= 10'h0;
      end else if (ms_tick && !disc_trip) begin
        dis_q <= dis_q + 10'h1;
      end
      if (state_q == ST_CLASS && state_d != ST_CLASS) begin
        class_q <= class_meas;
      end
      if (state_d == ST_SHUT && state_q != ST_SHUT) begin
        fault_q <= !disc_trip || oc_trip || out_uv_trip || pwr_trip;
      end
      // Open circuit wins over a fault entered in the same cycle
      if (in_det && sen_q.open_circuit) begin
        lock_q <= 1'b0;
      end else if (state_q == ST_SHUT && fault_q && !cfg_q.auto_rst) begin
        lock_q <= 1'b1;
      end
      // Slow ramp, one code per ms; held once feedback takes over
      if (state_q == ST_RAMP) begin
        if (ms_tick && ramp_q != 8'hff) begin
          ramp_q <= ramp_q + 8'h1;
        end
      end else if (state_q != ST_POWER) begin
        ramp_q <= DUTY_ZERO;
      end
    end
  end

  // ----------------------------------------------------------------
  // Output selection
  // ----------------------------------------------------------------
  wire conv_run = out_live;
  wire sw_on = out_live || (state_q == ST_SHUT);
  wire fast_on = (tmr_q % BLINK_FAST_MS) < (BLINK_FAST_MS >> 1);
  wire search_on = (state_q >= ST_DET_P1) && (state_q <= ST_DET_EVAL);
  wire led_on = (state_q == ST_POWER) ? 1'b1 :
                (state_q == ST_DENY || state_q == ST_FAULT) ? fast_on :
                search_on;
  wire [7:0] duty_sel = (state_q == ST_DET_P1) ? DUTY_PROBE_LO :
                        (state_q == ST_DET_P2) ? DUTY_PROBE_HI :
                        (state_q == ST_DET_P3) ? DUTY_PROBE_LO :
                        (state_q == ST_CLASS) ? DUTY_CLASS :
                        supervised ? ramp_q : DUTY_ZERO;
  wire [1:0] thr_sel = (class_q == 3'd1) ? THR_98 :
                       (class_q == 3'd2) ? THR_180 : THR_400;

  // ----------------------------------------------------------------
  // Output flops, converter clock and duty PWM
  // ----------------------------------------------------------------
  logic [7:0] cclk_cnt_q, pwm_cnt_q, duty_q;
  logic cclk_q, led_q, pass_n_q, sw_q, fb_q, cls_mode_q;
  logic duty_a_q, duty_b_q;
  wire cclk_wrap = (cclk_cnt_q == CONV_HALF_M1);
  wire [7:0] pwm_cnt_b = pwm_cnt_q ^ 8'h80;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cclk_cnt_q <= 8'h0;
      cclk_q <= 1'b0;
      pwm_cnt_q <= 8'h0;
      duty_q <= DUTY_ZERO;
      duty_a_q <= 1'b0;
      duty_b_q <= 1'b0;
      led_q <= 1'b1;
      pass_n_q <= 1'b1;
      sw_q <= 1'b0;
      fb_q <= 1'b0;
      cls_mode_q <= 1'b0;
    end else begin
      cclk_cnt_q <= (cclk_wrap || !conv_run) ? 8'h0 : cclk_cnt_q + 8'h1;
      cclk_q <= conv_run && (cclk_wrap ? !cclk_q : cclk_q);
      pwm_cnt_q <= pwm_cnt_q + 8'h1;
      duty_q <= duty_sel;
      duty_a_q <= pwm_cnt_q < duty_q;
      duty_b_q <= pwm_cnt_b < duty_q;
      led_q <= !led_on;
      pass_n_q <= !sw_on;
      sw_q <= sw_on;
      fb_q <= (state_q == ST_POWER);
      cls_mode_q <= (state_q == ST_CLASS);
    end
  end

  assign led_o = led_q;
  assign led_oe_n_o = !cfg_taken_q;
  assign pass_transistor_n_o = pass_n_q;
  assign switcher_transistor_o = sw_q;
  assign converter_clock_out_o = cclk_q;
  assign duty_out_a_o = duty_a_q;
  assign duty_out_b_o = duty_b_q;
  assign overload_threshold_o = thr_sel;
  assign classify_mode_o = cls_mode_q;
  assign feedback_en_o = fb_q;
  assign class_o = class_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_INACTIVE_UNTIL_CFG: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i)
    !cfg_taken_q |-> pass_transistor_n_o && !switcher_transistor_o
      && !converter_clock_out_o)
    else $error("Output active before configuration was taken");

  AST_LED_PIN_TURNS_OUT: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i)
    cfg_taken_q |=> !led_oe_n_o && $stable(cfg_q))
    else $error("Status pin not driven after configuration");

  AST_DETECT_OUTPUT_OFF: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i)
    in_det |=> pass_transistor_n_o && !switcher_transistor_o)
    else $error("Output enabled during detection");

  AST_ZERO_HOLD_LEN: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i)
    (state_q == ST_DET_ZERO && state_d == ST_DET_P1) |->
      tmr_q == DET_ZERO_MS)
    else $error("Zero hold not 250 ms");

  AST_OC_TRIPS: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i)
    oc_trip |=> state_q == ST_SHUT)
    else $error("Overcurrent timer expiry missed");

  AST_SHUT_ORDER: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i)
    (state_q == ST_SHUT) |=>
      (!converter_clock_out_o && switcher_transistor_o)
      ##1 !switcher_transistor_o)
    else $error("Converter clock not stopped before switcher");

  AST_LED_STEADY_POWER: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i)
    (state_q == ST_POWER) [*2] |-> !led_o)
    else $error("LED not steady on while powered");

  AST_DISCONNECT: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i)
    disc_trip |=> state_q == ST_SHUT ##1 state_q == ST_BACKOFF
      || state_q == ST_FAULT)
    else $error("Disconnect not acted on");

  AST_DENY_RETURN: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i)
    (state_q == ST_DENY && tmr_q >= DENY_MS) |=> state_q == ST_WAIT_UV)
    else $error("Denial did not return to detection");

endmodule

`default_nettype wire

//--- verification/pse_pd_model.sv
// Powered-device model behind the port: produces the digitised sense results
`timescale 1ns/1ps
`default_nettype none

module pse_pd_model
  import pse_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [3:0] cfg_level_i,
  input wire logic present_i,
  input wire logic [2:0] cls_i,
  input wire logic [1:0] load_i,
  input wire logic led_oe_n_i,
  input wire logic pass_transistor_n_i,
  input wire logic switcher_transistor_i,
  input wire logic classify_mode_i,
  output pse_sense_s sense_o
);
  // ----------------------------------------------------------------
  // Port power state
  // ----------------------------------------------------------------
  logic powered;
  logic run;
  logic [7:0] ramp_q;

  assign powered = !pass_transistor_n_i && switcher_transistor_i;
  assign run = powered && !classify_mode_i;

  // Output voltage climbs for 255 cycles before reaching the set point
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ramp_q <= 8'h00;
    end else if (!run) begin
      ramp_q <= 8'h00;
    end else if (ramp_q != 8'hff) begin
      ramp_q <= ramp_q + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Sense results
  // ----------------------------------------------------------------
  always_comb begin
    sense_o = '0;
    // Pin turned output: divider level no longer meaningful, so scramble it
    sense_o.cfg_level = led_oe_n_i ? cfg_level_i : ~cfg_level_i;
    sense_o.signature_good = present_i && pass_transistor_n_i;
    sense_o.open_circuit = !present_i && pass_transistor_n_i;
    sense_o.cls_6p5 = powered && classify_mode_i && cls_i >= 3'd1;
    sense_o.cls_14p5 = powered && classify_mode_i && cls_i >= 3'd2;
    sense_o.cls_23 = powered && classify_mode_i && cls_i >= 3'd3;
    sense_o.over_cut = run && load_i == 2'd1;
    sense_o.below_min = run && (load_i == 2'd2 || !present_i);
    sense_o.at_setpoint = ramp_q == 8'hff;
    // Load code 3 sags the output below the undervoltage level
    sense_o.out_uv = powered && load_i == 2'd3;
  end
endmodule

`default_nettype wire

//--- verification/pse_port_sequencer_test.sv
// Self-checking bench for the port sequencer with a powered-device model
`timescale 1ns/1ps
`default_nettype none

module pse_port_sequencer_test
  import pse_pkg::*;
;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [3:0] cfg_level = 4'h0;
  logic present = 1'b0;
  logic [2:0] cls = 3'd2;
  logic [1:0] load = 2'd0;
  pse_sense_s sense;
  logic led_o, led_oe_n_o, pass_n, sw, conv_clk, duty_a, duty_b;
  logic [1:0] thr;
  logic classify_mode_o, feedback_en_o;
  logic [2:0] class_o;
  logic [4:0] mon;
  int err_count = 0;
  int checked = 0;
  int cycles = 0;
  int n;

  always #5 clk_sys_i = ~clk_sys_i;
  assign mon = {led_o, classify_mode_o, feedback_en_o, sw, pass_n};

  // Short ms tick keeps the multi-second timers affordable
  pse_port_sequencer #(.MS_CYCLES(10)) u_pse_port_sequencer (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .sense_i(sense),
    .led_o(led_o), .led_oe_n_o(led_oe_n_o), .pass_transistor_n_o(pass_n),
    .switcher_transistor_o(sw), .converter_clock_out_o(conv_clk),
    .duty_out_a_o(duty_a), .duty_out_b_o(duty_b),
    .overload_threshold_o(thr), .classify_mode_o(classify_mode_o),
    .feedback_en_o(feedback_en_o), .class_o(class_o));

  pse_pd_model u_pse_pd_model (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .cfg_level_i(cfg_level),
    .present_i(present), .cls_i(cls), .load_i(load),
    .led_oe_n_i(led_oe_n_o), .pass_transistor_n_i(pass_n),
    .switcher_transistor_i(sw), .classify_mode_i(classify_mode_o),
    .sense_o(sense));

  // ----------------------------------------------------------------
  // Helper tasks
  // ----------------------------------------------------------------
  task automatic close_out();
    $display("Comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [7:0] exp,
                     input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  task automatic chk_rng(input string name, input int lo, input int hi,
                         input int got);
    checked++;
    if (got < lo || got > hi) begin
      err_count++;
      $display("ERROR %s expected %0d..%0d seen %0d", name, lo, hi, got);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys_i);
    #1;
  endtask

  // Bounded wait for one monitored output; n returns cycles spent
  task automatic wait_bit(input int idx, input logic val, input int max,
                          output int k);
    k = 0;
    while (mon[idx] !== val && k < max) begin
      cyc(1);
      k++;
    end
  endtask

  task automatic led_toggles(input int k, output int t);
    logic last;
    t = 0;
    last = led_o;
    repeat (k) begin
      cyc(1);
      if (led_o !== last) t++;
      last = led_o;
    end
  endtask

  task automatic do_reset(input logic [3:0] lvl);
    rst_n_i = 1'b0;
    cfg_level = lvl;
    cyc(10);
    chk("rst_mon", 8'h11, {3'h0, mon});
    chk("rst_drv", 8'h04, {4'h0, conv_clk, led_oe_n_o, duty_a, duty_b});
    cyc(10);
    rst_n_i = 1'b1;
    cyc(4);
    chk("cfg_pin_input", 8'h01, {7'h00, led_oe_n_o});
    cyc(1);
    chk("cfg_pin_output", 8'h00, {7'h00, led_oe_n_o});
  endtask

  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 100000) begin
      err_count++;
      $display("ERROR timeout expected finish seen %0d cycles", cycles);
      close_out();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    // Supply level: endpoint, auto restart, 15.4 W
    do_reset(4'h0);
    cyc(1000);
    chk("led_zero", 8'h01, {7'h00, led_o});
    n = 0;
    repeat (300) begin
      cyc(1);
      if (duty_a !== 1'b0 || duty_b !== 1'b0) n++;
    end
    chk_rng("duty_zero", 0, 0, n);
    cyc(1410);
    chk("led_probe", 8'h00, {7'h00, led_o});
    // Any 128 cycles of both phases sum to the duty code
    n = 0;
    repeat (128) begin
      cyc(1);
      if (duty_a === 1'b1) n++;
      if (duty_b === 1'b1) n++;
    end
    chk("duty_probe_hi", DUTY_PROBE_HI, 8'(n));
    cyc(562);
    chk("led_retry", 8'h01, {7'h00, led_o});
    wait_bit(0, 1'b0, 3000, n);
    chk_rng("no_power_open", 3000, 3000, n);
    present = 1'b1;
    wait_bit(3, 1'b1, 4000, n);
    chk("class_outs", 8'h01, {6'h00, pass_n, sw});
    wait_bit(3, 1'b0, 300, n);
    chk("class_val", 8'h02, {5'h00, class_o});
    chk("thr_sel", {6'h00, THR_180}, {6'h00, thr});
    wait_bit(2, 1'b1, 1000, n);
    chk_rng("ramp_wait", 0, 999, n);
    chk("led_steady", 8'h00, {7'h00, led_o});
    wait_bit(4, 1'b1, 500, n);
    chk_rng("led_held", 500, 500, n);
    n = 0;
    while (conv_clk !== 1'b1 && n < 500) begin
      cyc(1);
      n++;
    end
    n = 0;
    while (conv_clk === 1'b1 && n < 1000) begin
      cyc(1);
      n++;
    end
    chk_rng("conv_high", 200, 200, n);
    n = 0;
    while (conv_clk === 1'b0 && n < 1000) begin
      cyc(1);
      n++;
    end
    chk_rng("conv_low", 200, 200, n);
    chk("powered", 8'h00, {7'h00, pass_n});
    // Overload until the timer trips
    load = 2'd1;
    wait_bit(1, 1'b0, 1000, n);
    chk_rng("oc_trip", 585, 630, n);
    cyc(2);
    chk("oc_off", 8'h02, {6'h00, pass_n, conv_clk});
    load = 2'd0;
    led_toggles(2000, n);
    chk_rng("fault_flash", 3, 5, n);
    wait_bit(0, 1'b0, 26000, n);
    chk_rng("auto_restart", 21000, 21700, n);
    // Disconnect while powered
    wait_bit(2, 1'b1, 1000, n);
    load = 2'd2;
    wait_bit(1, 1'b0, 4000, n);
    chk_rng("disc_trip", 3490, 3545, n);
    load = 2'd0;
    wait_bit(0, 1'b0, 8000, n);
    chk_rng("backoff_end", 5650, 5800, n);
    // Level 2.0 V: 4 W only, class 2 must be denied
    do_reset(4'h5);
    wait_bit(3, 1'b1, 4000, n);
    wait_bit(3, 1'b0, 300, n);
    chk("deny_class", 8'h02, {5'h00, class_o});
    wait_bit(0, 1'b1, 20, n);
    chk_rng("deny_off", 0, 19, n);
    led_toggles(2000, n);
    chk_rng("deny_flash", 3, 5, n);
    wait_bit(3, 1'b1, 24000, n);
    chk_rng("deny_retry", 21000, 21500, n);
    // Output sag while classifying shuts the port
    load = 2'd3;
    wait_bit(1, 1'b0, 20, n);
    chk_rng("uv_trip", 5, 8, n);
    close_out();
  end
endmodule

`default_nettype wire
